/* File: core/pfrw_pkg.sv */
// package: register map, field positions and constants of the row writer
package pfrw_pkg;
  // register word indices (byte address = index * 4)
  localparam logic [3:0] PFRW_IDX_ADDR_LOW  = 4'h0;
  localparam logic [3:0] PFRW_IDX_ADDR_HIGH = 4'h1;
  localparam logic [3:0] PFRW_IDX_DATA_LOW  = 4'h2;
  localparam logic [3:0] PFRW_IDX_DATA_HIGH = 4'h3;
  localparam logic [3:0] PFRW_IDX_CTRL      = 4'h4;
  localparam logic [3:0] PFRW_IDX_KEY       = 4'h5;
  localparam logic [3:0] PFRW_IDX_STATUS    = 4'h6;
  // control register bit positions
  localparam int PFRW_BIT_GO     = 1;
  localparam int PFRW_BIT_MODIFY = 2;
  localparam int PFRW_BIT_LATCH  = 5;
  localparam int PFRW_BIT_SPACE  = 6;
  // unlock keys, written in this order
  localparam logic [7:0] PFRW_KEY_FIRST  = 8'h55;
  localparam logic [7:0] PFRW_KEY_SECOND = 8'hAA;
  // blank latch value and latch geometry
  localparam logic [13:0] PFRW_BLANK_WORD = 14'h3FFF;
  localparam int PFRW_LATCHES   = 32;
  localparam int PFRW_LAT_BITS  = 5;
  localparam int PFRW_ROW_BITS  = 10;
  // reset values
  localparam logic [7:0] PFRW_CTRL_RESET = 8'h00;
  localparam logic [7:0] PFRW_ADDR_RESET = 8'h00;
  // unlock progress
  typedef enum logic [1:0] {
    PFRW_UL_IDLE = 2'b00,
    PFRW_UL_KEY1 = 2'b01,
    PFRW_UL_KEY2 = 2'b11
  } pfrw_unlock_e;
  // sequencer states, gray along load-program-clear
  typedef enum logic [1:0] {
    PFRW_SQ_IDLE  = 2'b00,
    PFRW_SQ_PROG  = 2'b01,
    PFRW_SQ_CLEAR = 2'b11
  } pfrw_seq_e;
  // flash array write port bundle
  typedef struct packed {
    logic        we;
    logic [9:0]  row;
    logic [4:0]  col;
    logic [13:0] data;
  } pfrw_flash_s;
endpackage : pfrw_pkg

/* File: core/pfrw_row_writer.sv */
// row writer: wishbone registers, write latches and row program sequencer
//
// How it works
// RULE1: software sets address, loads latches, programs
// RULE2: software targets only erased flash words
// RULE3: erase covers exactly one row
// RULE4: program start never erases anything
// RULE5: program writes one to 32 latches
// RULE6: row from upper ten address bits
// RULE7: program touches only the selected row
// RULE8: latches reset blank after each operation
// RULE9: unloaded latches program as blank words
// RULE10: unlock in latch mode loads data word
// RULE11: only complete unlock loads or programs
// RULE12: software sets modify permit first
// RULE13: software clears space select for flash
// RULE14: latch-only mode loads latch, no program
// RULE15: latch mode clear loads then programs row
// RULE16: software increments address per latch
// RULE17: unlock writes two keys then go
// RULE18: hardware clears go bit on completion
`timescale 1ns/100ps
module pfrw_row_writer
  import pfrw_pkg::*;
#(
  parameter int LATCHES = pfrw_pkg::PFRW_LATCHES   // write latches per row
) (
  input  wire logic                 clk_i,      // system clock, 20 MHz
  input  wire logic                 rst_i,      // synchronous reset, high
  input  wire logic                 wb_cyc_i,   // wishbone cycle
  input  wire logic                 wb_stb_i,   // wishbone strobe
  input  wire logic                 wb_we_i,    // wishbone write
  input  wire logic [5:0]           wb_adr_i,   // byte address
  input  wire logic [3:0]           wb_sel_i,   // byte enables
  input  wire logic [31:0]          wb_dat_i,   // write data
  output logic      [31:0]          wb_dat_o,   // read data
  output logic                      wb_ack_o,   // acknowledge
  input  wire logic                 erase_req_i,// row erase request
  input  wire logic                 erase_done_i,// array erase finished
  input  wire logic                 flash_ready_i,// array accepts a word
  output pfrw_pkg::pfrw_flash_s     flash_o,    // array write port
  output logic                      erase_o,    // row erase busy level
  output logic      [9:0]           erase_row_o // row being erased
);
  import pfrw_pkg::*;

  // every check below runs on the system clock and sleeps in reset
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]   addr_low_q;             // low address byte
  logic [6:0]   addr_high_q;            // high address bits
  logic [7:0]   data_low_q;             // low data byte
  logic [5:0]   data_high_q;            // high data bits
  logic         go_q;                   // program-go, cleared by hardware
  logic         modify_permit_q;        // write permission
  logic         latch_only_select_q;    // load only, no array program
  logic         space_select_q;         // alternate space when set
  pfrw_unlock_e unlock_q;               // unlock progress
  pfrw_seq_e    seq_q;                  // sequencer state
  logic [4:0]   col_q;                  // latch being programmed
  logic [13:0]  latch_q [LATCHES];      // write latches
  logic         erase_busy_q;           // erase in progress
  pfrw_flash_s  flash_q;                // registered array port
  logic [9:0]   erase_row_q;            // latched erase row
  logic         ack_q;                  // bus acknowledge
  logic [9:0]   prog_row_q;             // row captured at program start

  // bus decode
  logic         bus_req;                // request this cycle
  logic         bus_wr;                 // accepted write
  logic [3:0]   reg_idx;                // register word index
  logic         unlock_done;            // go written after both keys
  logic [9:0]   row_sel;                // selected row
  logic [4:0]   lat_sel;                // selected latch

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  // every writable register fits in one byte, so only sel[0] lets a write land
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
  assign reg_idx = wb_adr_i[5:2];
  assign row_sel = {addr_high_q, addr_low_q[7:5]};       // [RULE6]
  assign lat_sel = addr_low_q[4:0];                      // [RULE6]

  // a go write only counts right after the two keys with permission set;
  // flash space only, and never while the sequencer or an erase is busy
  assign unlock_done = bus_wr && reg_idx == PFRW_IDX_CTRL
                       && wb_dat_i[PFRW_BIT_GO] && unlock_q == PFRW_UL_KEY2
                       && modify_permit_q && !wb_dat_i[PFRW_BIT_SPACE]
                       && seq_q == PFRW_SQ_IDLE && !erase_busy_q; // [RULE11]

  ////////////////////////////////////////////////////////////////////////////
  // wishbone acknowledge: one cycle after the request, drops next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end
  assign wb_ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered with the acknowledge; unmapped reads as zero
  // status lets software watch the column advance during a program
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      unique case (reg_idx)
        PFRW_IDX_ADDR_LOW:  wb_dat_o <= {24'h000000, addr_low_q};
        PFRW_IDX_ADDR_HIGH: wb_dat_o <= {25'h0000000, addr_high_q};
        PFRW_IDX_DATA_LOW:  wb_dat_o <= {24'h000000, data_low_q};
        PFRW_IDX_DATA_HIGH: wb_dat_o <= {26'h0000000, data_high_q};
        PFRW_IDX_CTRL: begin
          wb_dat_o <= {24'h000000, 1'b0, space_select_q,
                       latch_only_select_q, 2'b00, modify_permit_q,
                       go_q, 1'b0};
        end
        PFRW_IDX_STATUS: begin
          wb_dat_o <= {22'h000000, erase_busy_q, col_q,
                       seq_q != PFRW_SQ_IDLE, unlock_q, 1'b0};
        end
        default:            wb_dat_o <= 32'h0000_0000; // key reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and data registers; software steps the address itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_low_q  <= PFRW_ADDR_RESET;
      addr_high_q <= PFRW_ADDR_RESET[6:0];
      data_low_q  <= 8'h00;
      data_high_q <= 6'h00;
    end else if (bus_wr) begin
      if (reg_idx == PFRW_IDX_ADDR_LOW) begin
        addr_low_q <= wb_dat_i[7:0];                     // [RULE16]
      end
      if (reg_idx == PFRW_IDX_ADDR_HIGH) begin
        addr_high_q <= wb_dat_i[6:0];
      end
      if (reg_idx == PFRW_IDX_DATA_LOW) begin
        data_low_q <= wb_dat_i[7:0];
      end
      if (reg_idx == PFRW_IDX_DATA_HIGH) begin
        data_high_q <= wb_dat_i[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits; go falls when the requested operation completes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_q                <= PFRW_CTRL_RESET[PFRW_BIT_GO];
      modify_permit_q     <= PFRW_CTRL_RESET[PFRW_BIT_MODIFY];
      latch_only_select_q <= PFRW_CTRL_RESET[PFRW_BIT_LATCH];
      space_select_q      <= PFRW_CTRL_RESET[PFRW_BIT_SPACE];
    end else begin
      if (bus_wr && reg_idx == PFRW_IDX_CTRL) begin
        modify_permit_q     <= wb_dat_i[PFRW_BIT_MODIFY];   // [RULE12]
        latch_only_select_q <= wb_dat_i[PFRW_BIT_LATCH];
        space_select_q      <= wb_dat_i[PFRW_BIT_SPACE];    // [RULE13]
      end
      // a latch load is done in the same edge, so go never shows set;
      // a program keeps go high until the clear state ends
      if (unlock_done && !wb_dat_i[PFRW_BIT_LATCH]) begin
        go_q <= 1'b1;
      end else if (seq_q == PFRW_SQ_CLEAR) begin
        go_q <= 1'b0;                                     // [RULE18]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock tracker: any other bus write in between aborts it
  // reads leave it alone, so software may poll status between keys
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_q <= PFRW_UL_IDLE;
    end else if (bus_wr) begin
      if (reg_idx == PFRW_IDX_KEY && wb_dat_i[7:0] == PFRW_KEY_FIRST) begin
        unlock_q <= PFRW_UL_KEY1;                         // [RULE17]
      end else if (reg_idx == PFRW_IDX_KEY && unlock_q == PFRW_UL_KEY1
                   && wb_dat_i[7:0] == PFRW_KEY_SECOND) begin
        unlock_q <= PFRW_UL_KEY2;
      end else begin
        unlock_q <= PFRW_UL_IDLE;                         // [RULE11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // row program sequencer: walks every latch of the row, then blanks them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q <= PFRW_SQ_IDLE;
      col_q <= 5'h00;
    end else begin
      unique case (seq_q)
        PFRW_SQ_IDLE: begin
          col_q <= 5'h00;
          if (unlock_done && !wb_dat_i[PFRW_BIT_LATCH]) begin
            seq_q <= PFRW_SQ_PROG;                        // [RULE15]
          end
        end
        PFRW_SQ_PROG: begin
          // column stops at the last latch, so no neighbouring row is hit
          // a stalled array holds the column, so no word is skipped
          if (flash_ready_i) begin
            if (col_q == 5'(LATCHES - 1)) begin
              seq_q <= PFRW_SQ_CLEAR;                     // [RULE5]
            end else begin
              col_q <= col_q + 5'h01;                     // [RULE7]
            end
          end
        end
        PFRW_SQ_CLEAR: seq_q <= PFRW_SQ_IDLE;
        default:       seq_q <= PFRW_SQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write latches: loaded on unlock, blanked after program or erase
  always_ff @(posedge clk_i) begin
    if (rst_i || seq_q == PFRW_SQ_CLEAR || (erase_busy_q && erase_done_i))
    begin
      for (int i = 0; i < LATCHES; i++) begin
        latch_q[i] <= PFRW_BLANK_WORD;                    // [RULE8] [RULE9]
      end
    end else if (unlock_done) begin
      // latch-only or final word: both load the addressed latch
      latch_q[lat_sel] <= {data_high_q, data_low_q};      // [RULE10] [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program row: captured when the program starts, so an address write
  // made while the row streams out cannot steer words into another row
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_row_q <= 10'h000;
    end else if (unlock_done && !wb_dat_i[PFRW_BIT_LATCH]) begin
      prog_row_q <= row_sel;                              // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array port: the program path carries no erase strobe at all
  // latch data is fetched in the same edge as its strobe, both registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_q <= '0;
    end else begin
      flash_q.we   <= seq_q == PFRW_SQ_PROG && flash_ready_i; // [RULE4]
      flash_q.row  <= prog_row_q;                         // [RULE7]
      flash_q.col  <= col_q;
      flash_q.data <= latch_q[col_q];
    end
  end
  assign flash_o = flash_q;

  ////////////////////////////////////////////////////////////////////////////
  // row erase: one row per request, refused while programming
  // a program in flight owns the latches, so an erase request is only taken while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_busy_q <= 1'b0;
      erase_row_q  <= 10'h000;
    end else if (!erase_busy_q) begin
      if (erase_req_i && seq_q == PFRW_SQ_IDLE && modify_permit_q) begin
        erase_busy_q <= 1'b1;
        erase_row_q  <= row_sel;                          // [RULE3]
      end
    end else if (erase_done_i) begin
      erase_busy_q <= 1'b0;
    end
  end
  assign erase_o     = erase_busy_q;
  assign erase_row_o = erase_row_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks: go and the unlock
  a_go_needs_keys: assert property ( // [RULE11]
    $rose(go_q) |-> $past(unlock_q) == PFRW_UL_KEY2)
    else $error("go rose without unlock");
  a_go_clears: assert property ( // [RULE18]
    seq_q == PFRW_SQ_CLEAR |=> !go_q)
    else $error("go not cleared after program");
  // checks: write latches
  a_blank_after: assert property ( // [RULE8]
    seq_q == PFRW_SQ_CLEAR |=> latch_q[0] == PFRW_BLANK_WORD
      && latch_q[LATCHES-1] == PFRW_BLANK_WORD)
    else $error("latches not blank after program");
  a_blank_erase: assert property ( // [RULE8]
    erase_busy_q && erase_done_i |=> latch_q[0] == PFRW_BLANK_WORD
      && latch_q[LATCHES-1] == PFRW_BLANK_WORD)
    else $error("latches not blank after erase");
  a_latch_load: assert property ( // [RULE10]
    unlock_done |=> latch_q[$past(lat_sel)] ==
      {$past(data_high_q), $past(data_low_q)})
    else $error("latch not loaded");
  // checks: the row program
  a_latch_only: assert property ( // [RULE14]
    unlock_done && wb_dat_i[PFRW_BIT_LATCH] |=> seq_q == PFRW_SQ_IDLE)
    else $error("latch-only mode started program");
  a_prog_start: assert property ( // [RULE15]
    unlock_done && !wb_dat_i[PFRW_BIT_LATCH] |=> seq_q == PFRW_SQ_PROG
      ##0 go_q)
    else $error("program did not start");
  a_prog_words: assert property ( // [RULE5]
    seq_q == PFRW_SQ_PROG && flash_ready_i && col_q == 5'(LATCHES - 1)
      |=> seq_q == PFRW_SQ_CLEAR && flash_q.we
      && flash_q.col == 5'(LATCHES - 1))
    else $error("last latch not written before clear");
  a_row_fixed: assert property ( // [RULE7]
    flash_q.we && $past(flash_q.we) |-> flash_q.row == $past(flash_q.row))
    else $error("program crossed a row");
  a_prog_row: assert property ( // [RULE7]
    flash_q.we |-> flash_q.row == prog_row_q)
    else $error("word written outside the program row");
  // checks: program and erase never overlap, erase keeps one row
  a_no_erase_prog: assert property ( // [RULE4]
    $rose(erase_busy_q) |-> $past(seq_q) == PFRW_SQ_IDLE)
    else $error("erase began during program");
  a_prog_no_erase: assert property ( // [RULE4]
    seq_q != PFRW_SQ_IDLE |-> !erase_busy_q)
    else $error("erase busy while programming");
  a_erase_one_row: assert property ( // [RULE3]
    erase_busy_q && $past(erase_busy_q) |-> $stable(erase_row_q))
    else $error("erase row changed");
  // covers for the main scenarios
  c_latch_load: cover property (unlock_done && wb_dat_i[PFRW_BIT_LATCH]);
  c_row_prog: cover property (seq_q == PFRW_SQ_CLEAR);
  c_prog_stall: cover property (seq_q == PFRW_SQ_PROG && !flash_ready_i);
  c_erase: cover property (erase_busy_q && erase_done_i);
  c_unlock_cut: cover property (unlock_q == PFRW_UL_KEY1 && bus_wr
    && reg_idx != PFRW_IDX_KEY);
endmodule // pfrw_row_writer

/* File: sim/pfrw_flash_model.sv */
// flash array model: word store, ready stalls and timed row erase
`timescale 1ns/100ps
module pfrw_flash_model
  import pfrw_pkg::*;
(
  input  wire logic             clk_i,       // system clock
  input  wire logic             rst_i,       // synchronous reset
  input  pfrw_pkg::pfrw_flash_s flash_i,     // write port from the writer
  input  wire logic             erase_i,     // erase busy level
  input  wire logic [9:0]       erase_row_i, // row under erase
  output logic                  ready_o,     // array takes a word
  output logic                  done_o       // erase finished pulse
);
  logic [13:0] mem [0:32767]; // array words indexed by {row, col}
  logic [2:0]  tick_q;        // stall pattern counter
  logic [2:0]  ecnt_q;        // erase duration counter
  initial for (int i = 0; i < 32768; i++) mem[i] = 14'h3FFF;
  // one stall in eight, so the writer must wait as well as stream
  assign ready_o = (tick_q != 3'h5);
  assign done_o  = (ecnt_q == 3'h6);
  ////////////////////////////////////////////////////////////////////////
  // timers: erase counter saturates so done pulses only once
  always_ff @(posedge clk_i) begin
    tick_q <= rst_i ? 3'h0 : tick_q + 3'h1;
    ecnt_q <= (rst_i | ~erase_i) ? 3'h0 : ecnt_q + {2'h0, ecnt_q != 3'h7};
  end
  // programming only clears bits; an erase blanks exactly one row
  always @(posedge clk_i) begin
    if (flash_i.we === 1'b1)
      mem[{flash_i.row, flash_i.col}] <= mem[{flash_i.row, flash_i.col}]
                                         & flash_i.data;
    if (done_o)
      for (int c = 0; c < 32; c++)
        mem[{erase_row_i, c[4:0]}] <= 14'h3FFF;
  end
endmodule // pfrw_flash_model

/* File: sim/tb.sv */
// testbench: register traffic, row programs, aborted unlock, row erase
`timescale 1ns/100ps
module tb;
  import pfrw_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, erase_req_i = 1'b0, erase_done_i, flash_ready_i;
  logic        erase_o;
  logic [9:0]  erase_row_o;
  pfrw_flash_s flash_o;
  int          bad_count = 0, n_compared = 0, cycles = 0, wr_cnt = 0;
  int          er_cnt = 0;      // cycles with the erase busy level up
  logic [31:0] lfsr = 32'h38AF; // fixed seed for repeatable runs
  logic [13:0] exp_row [32];    // expected words of the row under test
  always #25 clk_i = ~clk_i;
  pfrw_row_writer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .erase_req_i(erase_req_i),
    .erase_done_i(erase_done_i), .flash_ready_i(flash_ready_i),
    .flash_o(flash_o), .erase_o(erase_o), .erase_row_o(erase_row_o));
  pfrw_flash_model i_flash (.clk_i(clk_i), .rst_i(rst_i), .flash_i(flash_o),
    .erase_i(erase_o), .erase_row_i(erase_row_o), .ready_o(flash_ready_i),
    .done_o(erase_done_i));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [3:0] idx,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    chk({31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic ctrl(input logic go, input logic lo);
    logic [7:0] c;
    c = 8'h00;
    c[PFRW_BIT_MODIFY] = 1'b1; // space select stays 0
    c[PFRW_BIT_GO] = go;
    c[PFRW_BIT_LATCH] = lo;
    xfer(1'b1, PFRW_IDX_CTRL, c);
  endtask
  task automatic set_addr(input logic [9:0] row, input logic [4:0] col);
    xfer(1'b1, PFRW_IDX_ADDR_HIGH, {1'b0, row[9:3]});
    xfer(1'b1, PFRW_IDX_ADDR_LOW, {row[2:0], col});
  endtask
  // cut inserts a stray write between the two keys
  task automatic load(input logic [9:0] row, input logic [4:0] col,
                      input logic [13:0] d, input logic lo, input logic cut);
    set_addr(row, col);
    xfer(1'b1, PFRW_IDX_DATA_LOW, d[7:0]);
    xfer(1'b1, PFRW_IDX_DATA_HIGH, {2'b00, d[13:8]});
    xfer(1'b1, PFRW_IDX_KEY, PFRW_KEY_FIRST);
    if (cut)
      xfer(1'b1, PFRW_IDX_DATA_LOW, 8'h00);
    xfer(1'b1, PFRW_IDX_KEY, PFRW_KEY_SECOND);
    ctrl(1'b1, lo);
  endtask
  task automatic cmp_row(input logic [9:0] row);
    for (int c = 0; c < 32; c++)
      chk({18'h0, i_flash.mem[{row, c[4:0]}]}, {18'h0, exp_row[c]});
  endtask
  // n random latch loads, then the final word in column 31
  task automatic prog(input logic [9:0] row, input int n);
    int w0;
    int e0;
    logic [4:0] col;
    for (int c = 0; c < 32; c++)
      exp_row[c] = PFRW_BLANK_WORD;
    w0 = wr_cnt;
    e0 = er_cnt;
    for (int i = 0; i <= n; i++) begin
      lfsr = lfsr_next(lfsr);
      col = (i == n) ? 5'h1F : lfsr[20:16] % 5'h1F;
      if (i == n)
        chk(32'(wr_cnt - w0), 32'h0);
      exp_row[col] = lfsr[13:0];
      load(row, col, lfsr[13:0], i != n, 1'b0);
    end
    xfer(1'b0, PFRW_IDX_CTRL, 8'h00);
    chk({31'h0, rd[PFRW_BIT_GO]}, 32'h1);
    set_addr(~row, 5'h00); // address moves while the row streams
    for (int k = 0; k < 60 && rd[PFRW_BIT_GO] !== 1'b0; k++)
      xfer(1'b0, PFRW_IDX_CTRL, 8'h00);
    chk({31'h0, rd[PFRW_BIT_GO]}, 32'h0);
    chk(32'(wr_cnt - w0), 32'd32);
    chk(32'(er_cnt - e0), 32'h0);
    cmp_row(row);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // cycle limit and count of array writes
  always @(posedge clk_i) begin
    cycles++;
    if (flash_o.we === 1'b1)
      wr_cnt++;
    if (erase_o === 1'b1)
      er_cnt++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, PFRW_IDX_CTRL, 8'h00);
    chk(rd, {24'h0, PFRW_CTRL_RESET});
    xfer(1'b1, 4'h9, 8'hFF);
    xfer(1'b0, 4'h9, 8'h00);
    chk(rd, 32'h0); // unmapped place reads zero
    ctrl(1'b0, 1'b1);
    prog(10'h2A5, 6);
    chk({18'h0, i_flash.mem[{10'h2A6, 5'h00}]}, 32'h3FFF);
    load(10'h0F3, 5'h03, 14'h0123, 1'b1, 1'b1);
    prog(10'h0F3, 0);
    set_addr(10'h2A5, 5'h00);
    erase_req_i <= 1'b1;
    @(posedge clk_i);
    erase_req_i <= 1'b0;
    for (int k = 0; k < 8 && erase_o !== 1'b1; k++)
      @(posedge clk_i);
    chk({22'h0, erase_row_o}, {22'h0, 10'h2A5});
    for (int k = 0; k < 40 && erase_o !== 1'b0; k++)
      @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    cmp_row(10'h0F3);
    for (int c = 0; c < 32; c++)
      exp_row[c] = PFRW_BLANK_WORD;
    cmp_row(10'h2A5);
    report_and_stop();
  end
endmodule // tb
